// ===== mode_default_table.sv
// Default output geometry for each output mode
`timescale 1ns/1ns
`default_nettype none
`include "scan_out_regs.svh"
module mode_default_table
  import scan_out_pkg::*;
(
  mode_defaults_if.table_side md
);
  always_comb begin
    md.pix = `RST_PIX;
    md.lines = `RST_LINES;
    md.hoff = `RST_HOFF;
    md.voff = `RST_VOFF;
    case (md.key)
      MODE_PAL: begin
        md.pix = `PIX_PAL;
        md.lines = `LINES_PAL;
        md.hoff = `HOFF_PAL;
        md.voff = `VOFF_PAL;
      end
      MODE_VGA: begin
        md.pix = `PIX_VGA;
        md.lines = `LINES_VGA;
        md.hoff = `HOFF_VGA;
        md.voff = `VOFF_VGA;
      end
      MODE_SVGA: begin
        md.pix = `PIX_SVGA;
        md.lines = `LINES_SVGA;
        md.hoff = `HOFF_SVGA;
        md.voff = `VOFF_SVGA;
      end
      MODE_HZ100_PAL: begin
        md.pix = `PIX_HZ100;
        md.lines = `LINES_HZ100;
        md.hoff = `HOFF_HZ100;
        md.voff = `VOFF_NTSC;
      end
      MODE_SUPER_NTSC: begin
        md.pix = `PIX_SUPER;
        md.lines = `LINES_NTSC;
        md.hoff = `HOFF_SUPER;
        md.voff = `VOFF_NTSC;
      end
      MODE_SUPER_PAL: begin
        md.pix = `PIX_SUPER;
        md.lines = `LINES_PAL;
        md.hoff = `HOFF_SUPER;
        md.voff = `VOFF_PAL;
      end
      default: begin
        md.pix = `PIX_NTSC;
        md.lines = `LINES_NTSC;
        md.hoff = `HOFF_NTSC;
        md.voff = `VOFF_NTSC;
      end
    endcase
  end
endmodule : mode_default_table
`default_nettype wire

// ===== mode_defaults_if.sv
// Mode key and the matching default geometry
`timescale 1ns/1ns
`default_nettype none
interface mode_defaults_if;
  import scan_out_pkg::*;
  logic [3:0] key;
  word_t pix;
  word_t lines;
  word_t hoff;
  word_t voff;
  modport table_side (input key, output pix, lines, hoff, voff);
  modport user_side (output key, input pix, lines, hoff, voff);
endinterface : mode_defaults_if
`default_nettype wire

// ===== param_store_model.sv
// Behavioural internal controller that serves the parameter mailbox
`timescale 1ns/1ns
`default_nettype none
module param_store_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:255];
  logic [3:0] wait_reg;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'(i * 257 + 16'h1234);
    end
  end

  // ****************************************
  // Answer each request once, after i_delay
  // ****************************************
  // one completion per command
  // read result handed back with ack
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_ack <= 1'b0;
      wait_reg <= 4'h0;
      o_rdata <= 16'h5a5a;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      wait_reg <= 4'h0;
      o_rdata <= ~o_rdata;
    end else if (i_req && wait_reg >= i_delay) begin
      o_ack <= 1'b1;
      if (i_write) begin
        mem[i_addr] <= i_wdata;
        o_rdata <= ~o_rdata;
      end else begin
        o_rdata <= mem[i_addr];
      end
    end else begin
      // Idle data lines toggle so stale values never match
      o_rdata <= ~o_rdata;
      if (i_req) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule : param_store_model
`default_nettype wire

// ===== recalc_timer.sv
// Countdown that marks the end of a limit recomputation
`timescale 1ns/1ns
`default_nettype none
module recalc_timer #(
  parameter int unsigned CYCLES = 2500000,
  parameter int unsigned CW = 22
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);
  logic [CW-1:0] cnt_reg;
  logic busy_reg;

  // A new start restarts the full interval
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (i_start) begin
      cnt_reg <= CW'(CYCLES - 1);
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign o_busy = busy_reg;
  assign o_done = busy_reg && (cnt_reg == '0) && !i_start;
endmodule : recalc_timer
`default_nettype wire

// ===== scan_out_pkg.sv
// Types shared by the output register bank
package scan_out_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [3:0] {
    MODE_NTSC = 4'b0000,
    MODE_PAL = 4'b0001,
    MODE_HZ100_PAL = 4'b0101,
    MODE_PROG_NTSC = 4'b0110,
    MODE_SUPER_NTSC = 4'b1000,
    MODE_SUPER_PAL = 4'b1001,
    MODE_VGA = 4'b1010,
    MODE_SVGA = 4'b1011
  } tv_mode_e;
  typedef enum logic [3:0] {
    CMD_DONE = 4'h0,
    CMD_READ = 4'h1,
    CMD_WRITE = 4'h2
  } cfg_cmd_e;
  typedef enum logic {
    MB_IDLE = 1'b0,
    MB_BUSY = 1'b1
  } mbox_state_e;
endpackage : scan_out_pkg

// ===== scan_out_regs.sv
// Output geometry, vertical pan and configuration mailbox registers
`timescale 1ns/1ns
`default_nettype none
`include "scan_out_regs.svh"
module scan_out_regs
  import scan_out_pkg::*;
#(
  parameter int unsigned RECALC_CYCLES = `RECALC_CYCLES,
  parameter int unsigned RECALC_CW = 22
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_output_clock_select,
  input wire logic i_progressive_select,
  input wire logic i_broadcast_standard_select,
  input wire logic i_magnify_en,
  input wire logic [15:0] i_vpan_min,
  input wire logic [15:0] i_vpan_max,
  output logic [15:0] o_vpan_window_line,
  output logic o_limits_busy,
  output logic [15:0] o_output_pixels_per_line,
  output logic [15:0] o_output_line_count,
  output logic [15:0] o_output_horizontal_offset,
  output logic [15:0] o_output_vertical_offset,
  output logic o_mode_recalc,
  output logic o_status_error_set,
  output logic o_param_req,
  output logic o_param_write,
  output logic [7:0] o_param_addr,
  output logic [15:0] o_param_wdata,
  input wire logic i_param_ack,
  input wire logic [15:0] i_param_rdata
);
  // ****************************************
  // Declarations
  // ****************************************
  word_t vpan_reg;
  word_t pix_reg;
  word_t lines_reg;
  word_t hoff_reg;
  word_t voff_reg;
  word_t cfg_data_reg;
  logic [7:0] cfg_addr_reg;
  logic [3:0] cmd_reg;
  logic [3:0] mode_prev_reg;
  logic [15:0] vpan_line_reg;
  logic recalc_reg;
  logic error_reg;
  logic [7:0] rdata_reg;
  mbox_state_e state_reg;
  mbox_state_e state_next;
  logic [3:0] mode_key;
  logic mode_change;
  logic timer_done;
  logic timer_busy;
  logic mb_start;
  logic [6:0] wr_pair;
  logic wr_hi;
  word_t pix_new;
  word_t lines_new;

  mode_defaults_if md ();

  // ****************************************
  // Byte helpers and decode
  // ****************************************
  // merge one byte into its pair
  function automatic word_t put_byte(word_t old, logic hi, logic [7:0] b);
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : put_byte

  assign wr_pair = i_addr[7:1];
  assign wr_hi = i_addr[0];
  assign pix_new = {i_wdata, pix_reg[7:0]};
  assign lines_new = {i_wdata, lines_reg[7:0]};

  function automatic logic hit(logic [7:0] off, logic [6:0] pair);
    hit = (off[7:1] == pair);
  endfunction : hit

  // ****************************************
  // Mode tracking and defaults
  // ****************************************
  assign mode_key = {i_output_clock_select, i_progressive_select,
                     i_broadcast_standard_select};
  assign md.key = mode_key;
  assign mode_change = (mode_key != mode_prev_reg);

  mode_default_table u_table (
    .md(md.table_side)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mode_prev_reg <= `RST_MODE;
    end else begin
      mode_prev_reg <= mode_key;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pix_reg <= `RST_PIX;
      lines_reg <= `RST_LINES;
      hoff_reg <= `RST_HOFF;
      voff_reg <= `RST_VOFF;
    end else if (mode_change) begin
      pix_reg <= md.pix;
      lines_reg <= md.lines;
      hoff_reg <= md.hoff;
      voff_reg <= md.voff;
    end else if (i_wr_en) begin
      if (hit(`OFF_PIX, wr_pair)) begin
        pix_reg <= put_byte(pix_reg, wr_hi, i_wdata);
      end
      if (hit(`OFF_LINES, wr_pair)) begin
        lines_reg <= put_byte(lines_reg, wr_hi, i_wdata);
      end
      if (hit(`OFF_HOFF, wr_pair)) begin
        hoff_reg <= put_byte(hoff_reg, wr_hi, i_wdata);
      end
      if (hit(`OFF_VOFF, wr_pair)) begin
        voff_reg <= put_byte(voff_reg, wr_hi, i_wdata);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      recalc_reg <= 1'b0;
      error_reg <= 1'b0;
    end else begin
      recalc_reg <= 1'b0;
      error_reg <= 1'b0;
      if (i_wr_en && wr_hi && !mode_change) begin
        if (hit(`OFF_PIX, wr_pair)) begin
          if (pix_new < `RANGE_MIN || pix_new > `RANGE_MAX) begin
            error_reg <= 1'b1;
          end else begin
            recalc_reg <= 1'b1;
          end
        end
        if (hit(`OFF_LINES, wr_pair)) begin
          if (lines_new < `RANGE_MIN || lines_new > `RANGE_MAX) begin
            error_reg <= 1'b1;
          end else begin
            recalc_reg <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Vertical pan
  // ****************************************
  // limits ready within the recompute interval
  recalc_timer #(
    .CYCLES(RECALC_CYCLES),
    .CW(RECALC_CW)
  ) u_timer (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(i_wr_en && hit(`OFF_VPAN, wr_pair)),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      vpan_reg <= `RST_VPAN;
    end else if (i_wr_en && hit(`OFF_VPAN, wr_pair)) begin
      vpan_reg <= put_byte(vpan_reg, wr_hi, i_wdata);
    end else if (timer_done) begin
      if ($signed(vpan_reg) > $signed(i_vpan_max)) begin
        vpan_reg <= i_vpan_max;
      end else if ($signed(vpan_reg) < $signed(i_vpan_min)) begin
        vpan_reg <= i_vpan_min;
      end
    end
  end

  // window line from top, zoom only
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      vpan_line_reg <= `RST_VPAN;
    end else begin
      vpan_line_reg <= i_magnify_en ? vpan_reg : `RST_VPAN;
    end
  end

  // ****************************************
  // Configuration mailbox
  // ****************************************
  // read or write command code starts while idle
  assign mb_start = i_wr_en && hit(`OFF_CMD, wr_pair) && wr_hi &&
                    (state_reg == MB_IDLE) &&
                    (i_wdata[`CMD_MSB:0] == CMD_READ ||
                     i_wdata[`CMD_MSB:0] == CMD_WRITE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MB_IDLE: begin
        if (mb_start) begin
          state_next = MB_BUSY;
        end
      end
      MB_BUSY: begin
        if (i_param_ack) begin
          state_next = MB_IDLE;
        end
      end
      default: begin
        state_next = MB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= MB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cmd_reg <= CMD_DONE;
      cfg_addr_reg <= 8'h00;
    end else if (state_reg == MB_BUSY) begin
      if (i_param_ack) begin
        cmd_reg <= CMD_DONE;
      end
    end else if (i_wr_en && hit(`OFF_CMD, wr_pair)) begin
      if (!wr_hi) begin
        cfg_addr_reg <= i_wdata;
      end else if (mb_start) begin
        cmd_reg <= i_wdata[`CMD_MSB:0];
      end
    end
  end

  // read result lands in data register
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cfg_data_reg <= `RST_CFG;
    end else if (state_reg == MB_BUSY) begin
      if (i_param_ack && cmd_reg == CMD_READ) begin
        cfg_data_reg <= i_param_rdata;
      end
    end else if (i_wr_en && hit(`OFF_DATA, wr_pair)) begin
      cfg_data_reg <= put_byte(cfg_data_reg, wr_hi, i_wdata);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_reg <= 8'h00;
    end else if (i_rd_en) begin
      rdata_reg <= 8'h00;
      if (hit(`OFF_VPAN, i_addr[7:1])) begin
        rdata_reg <= i_addr[0] ? vpan_reg[15:8] : vpan_reg[7:0];
      end
      if (hit(`OFF_PIX, i_addr[7:1])) begin
        rdata_reg <= i_addr[0] ? pix_reg[15:8] : pix_reg[7:0];
      end
      if (hit(`OFF_LINES, i_addr[7:1])) begin
        rdata_reg <= i_addr[0] ? lines_reg[15:8] : lines_reg[7:0];
      end
      if (hit(`OFF_CMD, i_addr[7:1])) begin
        rdata_reg <= i_addr[0] ? {4'h0, cmd_reg} : cfg_addr_reg;
      end
      if (hit(`OFF_DATA, i_addr[7:1])) begin
        rdata_reg <= i_addr[0] ? cfg_data_reg[15:8] : cfg_data_reg[7:0];
      end
      if (hit(`OFF_HOFF, i_addr[7:1])) begin
        rdata_reg <= i_addr[0] ? hoff_reg[15:8] : hoff_reg[7:0];
      end
      if (hit(`OFF_VOFF, i_addr[7:1])) begin
        rdata_reg <= i_addr[0] ? voff_reg[15:8] : voff_reg[7:0];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_rdata = rdata_reg;
  assign o_vpan_window_line = vpan_line_reg;
  assign o_limits_busy = timer_busy;
  assign o_output_pixels_per_line = pix_reg;
  assign o_output_line_count = lines_reg;
  assign o_output_horizontal_offset = hoff_reg;
  assign o_output_vertical_offset = voff_reg;
  assign o_mode_recalc = recalc_reg;
  assign o_status_error_set = error_reg;
  assign o_param_req = (state_reg == MB_BUSY);
  assign o_param_write = (state_reg == MB_BUSY) && (cmd_reg == CMD_WRITE);
  assign o_param_addr = cfg_addr_reg;
  assign o_param_wdata = cfg_data_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_cmd_upper_zero: assert property (
    i_rd_en && i_addr == (`OFF_CMD | 8'h01)
    |=> o_rdata[7:4] == 4'h0 && ($past(o_param_req) || o_rdata == 8'h00))
    else $error("command upper nibble not zero");
  a_read_starts: assert property (
    mb_start && i_wdata[3:0] == CMD_READ
    |=> o_param_req && !o_param_write && cmd_reg == CMD_READ)
    else $error("read command did not start");
  a_read_result: assert property (
    o_param_req && i_param_ack && !o_param_write
    |=> cfg_data_reg == $past(i_param_rdata) && cmd_reg == CMD_DONE)
    else $error("read result not captured");
  a_pix_error: assert property (
    i_wr_en && i_addr == (`OFF_PIX | 8'h01) && !mode_change
    && pix_new > `RANGE_MAX |=> o_status_error_set && !o_mode_recalc)
    else $error("bad pixel count not flagged");
  a_lines_error: assert property (
    i_wr_en && i_addr == (`OFF_LINES | 8'h01) && !mode_change
    && lines_new < `RANGE_MIN |=> o_status_error_set && !o_mode_recalc)
    else $error("bad line count not flagged");
  a_mode_reload: assert property (
    mode_change |=> pix_reg == $past(md.pix) && voff_reg == $past(md.voff))
    else $error("mode change did not reload defaults");
  a_pan_clamp: assert property (
    timer_done && !i_wr_en && $signed(vpan_reg) > $signed(i_vpan_max)
    |=> vpan_reg == $past(i_vpan_max))
    else $error("pan not clamped to maximum");
  a_pan_gate: assert property (
    !i_magnify_en |=> o_vpan_window_line == 16'h0000)
    else $error("pan applied without magnify");
  a_cmd_done_idle: assert property (
    o_param_req && i_param_ack
    |=> !o_param_req ##1 (!o_param_req || $past(mb_start)))
    else $error("mailbox stayed busy after completion");
endmodule : scan_out_regs
`default_nettype wire

// ===== scan_out_regs.svh
// Offsets, reset values, mode defaults and timing for the output register bank
// Notes on behaviour
// - Byte pairs, low byte even, from 0x72
// - Pan zero is top edge, grows downward
// - Pan applies only while magnify enabled
// - Out-of-limit pan clamped to limit, readable
// - Limit recompute done within 25 ms
// - Pan is signed sixteen-bit value
// - Pixels per line valid 128 to 2047
// - Bad pixel count flags error, no recompute
// - Line count valid 128 to 2047
// - Bad line count flags error, no recompute
// - Mode field change reloads four defaults
// - Pixel count reset and per-mode defaults
// - Line count reset and per-mode defaults
// - Horizontal offset from sync, reset 178
// - Vertical offset from equalization pulses
// - Vertical offset reset and mode defaults
// - Command low byte address, high command
// - Codes read 1, write 2, done 0
// - Read result left in data register
`ifndef SCAN_OUT_REGS_SVH
`define SCAN_OUT_REGS_SVH

// ****************************************
// Register offsets, low byte of each pair
// ****************************************
`define OFF_VPAN 8'h72
`define OFF_PIX 8'h74
`define OFF_LINES 8'h76
`define OFF_CMD 8'h78
`define OFF_DATA 8'h7a
`define OFF_HOFF 8'h7c
`define OFF_VOFF 8'h7e

// ****************************************
// Reset values and fields
// ****************************************
`define RST_VPAN 16'h0000
`define RST_PIX 16'h0292
`define RST_LINES 16'h019c
`define RST_HOFF 16'h00b2
`define RST_VOFF 16'h0026
`define RST_CFG 16'h0000
`define RST_MODE 4'h0
`define CMD_MSB 3
`define RANGE_MIN 16'h0080
`define RANGE_MAX 16'h07ff

// ****************************************
// Per-mode defaults
// ****************************************
`define PIX_NTSC 16'h0292
`define PIX_PAL 16'h0334
`define PIX_VGA 16'h0280
`define PIX_SVGA 16'h0320
`define PIX_HZ100 16'h038c
`define PIX_SUPER 16'h0392
`define LINES_NTSC 16'h019c
`define LINES_PAL 16'h01f0
`define LINES_VGA 16'h01e0
`define LINES_SVGA 16'h0258
`define LINES_HZ100 16'h021c
`define HOFF_NTSC 16'h00b2
`define HOFF_PAL 16'h00e6
`define HOFF_VGA 16'h0084
`define HOFF_SVGA 16'h00b0
`define HOFF_HZ100 16'h00b4
`define HOFF_SUPER 16'h0122
`define VOFF_NTSC 16'h0026
`define VOFF_PAL 16'h002c
`define VOFF_VGA 16'h0028
`define VOFF_SVGA 16'h0024

// ****************************************
// Timing
// ****************************************
`define RECALC_MAX_MS 25
`define CLK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define RECALC_CYCLES (`RECALC_MAX_MS * `NS_PER_MS / `CLK_PERIOD_NS)

`endif

// ===== test_output_geometry_and_config_mailbox.sv
// Self-checking bench for the output geometry and mailbox registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module test_output_geometry_and_config_mailbox
  import scan_out_pkg::*;
;
  logic i_clk, i_rstn, i_wr_en, i_rd_en, i_progressive_select;
  logic i_broadcast_standard_select, i_magnify_en, o_limits_busy;
  logic o_mode_recalc, o_status_error_set, o_param_req, o_param_write;
  logic i_param_ack;
  logic [1:0] i_output_clock_select;
  logic [3:0] ack_delay;
  logic [7:0] i_addr, i_wdata, o_rdata, o_param_addr, c, a;
  word_t i_vpan_min, i_vpan_max, o_vpan_window_line, o_param_wdata;
  word_t o_output_pixels_per_line, o_output_line_count;
  word_t o_output_horizontal_offset, o_output_vertical_offset;
  word_t i_param_rdata, rnd, v, got, e;
  word_t pmem [0:255];
  word_t rst_tab [7] = '{16'h0000, 16'h0292, 16'h019c, 16'h0000,
                         16'h0000, 16'h00b2, 16'h0026};
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb};
  word_t pix_tab [8] = '{16'h0292, 16'h0334, 16'h038c, 16'h0292,
                         16'h0392, 16'h0392, 16'h0280, 16'h0320};
  word_t lin_tab [8] = '{16'h019c, 16'h01f0, 16'h021c, 16'h019c,
                         16'h019c, 16'h01f0, 16'h01e0, 16'h0258};
  word_t hof_tab [8] = '{16'h00b2, 16'h00e6, 16'h00b4, 16'h00b2,
                         16'h0122, 16'h0122, 16'h0084, 16'h00b0};
  word_t vof_tab [8] = '{16'h0026, 16'h002c, 16'h0026, 16'h0026,
                         16'h0026, 16'h002c, 16'h0028, 16'h0024};
  word_t vals [$] = '{16'h007f, 16'h0080, 16'h07ff, 16'h0800, 16'h0400};
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int sv;

  scan_out_regs #(.RECALC_CYCLES(8), .RECALC_CW(4)) dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_output_clock_select(i_output_clock_select),
    .i_progressive_select(i_progressive_select),
    .i_broadcast_standard_select(i_broadcast_standard_select),
    .i_magnify_en(i_magnify_en), .i_vpan_min(i_vpan_min),
    .i_vpan_max(i_vpan_max), .o_vpan_window_line(o_vpan_window_line),
    .o_limits_busy(o_limits_busy),
    .o_output_pixels_per_line(o_output_pixels_per_line),
    .o_output_line_count(o_output_line_count),
    .o_output_horizontal_offset(o_output_horizontal_offset),
    .o_output_vertical_offset(o_output_vertical_offset),
    .o_mode_recalc(o_mode_recalc), .o_status_error_set(o_status_error_set),
    .o_param_req(o_param_req), .o_param_write(o_param_write),
    .o_param_addr(o_param_addr), .o_param_wdata(o_param_wdata),
    .i_param_ack(i_param_ack), .i_param_rdata(i_param_rdata)
  );

  param_store_model partner (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_req(o_param_req),
    .i_write(o_param_write), .i_addr(o_param_addr), .i_wdata(o_param_wdata),
    .i_delay(ack_delay), .o_ack(i_param_ack), .o_rdata(i_param_rdata)
  );

  always #5 i_clk = ~i_clk;

  // ****************************************
  // Bus tasks and helpers
  // ****************************************
  function automatic word_t lfsr_next(input word_t x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge i_clk);
    i_wr_en = 1'b1;
    i_addr = ad;
    i_wdata = d;
    @(negedge i_clk);
    i_wr_en = 1'b0;
  endtask : wr

  task automatic wr16(input logic [7:0] ad, input word_t d);
    wr(ad, d[7:0]);
    wr(ad + 8'h01, d[15:8]);
  endtask : wr16

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(negedge i_clk);
    i_rd_en = 1'b1;
    i_addr = ad;
    @(negedge i_clk);
    i_rd_en = 1'b0;
    d = o_rdata;
  endtask : rd

  task automatic rd16(input logic [7:0] ad, output word_t d);
    logic [7:0] lo, hi;
    rd(ad, lo);
    rd(ad + 8'h01, hi);
    d = {hi, lo};
  endtask : rd16

  task automatic poll_done();
    logic [7:0] cr;
    cr = 8'hff;
    for (int n = 0; n < 40 && cr !== 8'h00; n++) begin
      rd(8'h79, cr);
      repeat (2) @(negedge i_clk);
    end
    `CHK(cr, 8'h00)
  endtask : poll_done

  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_clk, i_rstn, i_wr_en, i_rd_en, i_magnify_en} = 5'h00;
    {i_output_clock_select, i_progressive_select} = 3'h0;
    i_broadcast_standard_select = 1'b0;
    {i_addr, i_wdata, ack_delay} = 20'h00000;
    i_vpan_min = 16'hff9c;
    i_vpan_max = 16'h012c;
    rnd = 16'h0054;
    for (int i = 0; i < 256; i++) begin
      pmem[i] = 16'(i * 257 + 16'h1234);
    end
    repeat (6) @(negedge i_clk);
    i_rstn = 1'b1;
    for (int j = 0; j < 7; j++) begin
      if (j != 4) begin
        rd16(8'h72 + 8'(2 * j), got);
        `CHK(got, rst_tab[j])
      end
    end
    rd(8'h70, c);
    `CHK(c, 8'h00)
    for (int m = 1; m <= 8; m++) begin
      @(negedge i_clk);
      {i_output_clock_select, i_progressive_select,
       i_broadcast_standard_select} = codes[m % 8];
      repeat (3) @(negedge i_clk);
      `CHK(o_output_pixels_per_line, pix_tab[m % 8])
      `CHK(o_output_line_count, lin_tab[m % 8])
      `CHK(o_output_horizontal_offset, hof_tab[m % 8])
      `CHK(o_output_vertical_offset, vof_tab[m % 8])
    end
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr_next(rnd);
      v = (k == 0) ? 16'h8000 : (k == 1) ? 16'h7fff : rnd;
      sv = int'($signed(v));
      e = (sv > 300) ? 16'h012c : (sv < -100) ? 16'hff9c : v;
      wr16(8'h72, v);
      `CHK(o_limits_busy, 1'b1)
      repeat (10) @(negedge i_clk);
      `CHK(o_limits_busy, 1'b0)
      rd16(8'h72, got);
      `CHK(got, e)
      i_magnify_en = k[0];
      repeat (2) @(negedge i_clk);
      `CHK(o_vpan_window_line, k[0] ? e : 16'h0000)
    end
    for (int q = 0; q < vals.size(); q++) begin
      for (int r = 0; r < 2; r++) begin
        wr16(r ? 8'h76 : 8'h74, vals[q]);
        `CHK(o_status_error_set, !(q inside {1, 2, 4}))
        `CHK(o_mode_recalc, q inside {1, 2, 4})
      end
      if (q inside {1, 2, 4}) begin
        rd16(8'h74, got);
        `CHK(got, vals[q])
        rd16(8'h76, got);
        `CHK(got, vals[q])
      end
    end
    for (int k = 0; k < 4; k++) begin
      ack_delay = k[0] ? 4'h9 : 4'h0;
      rnd = lfsr_next(rnd);
      a = rnd[7:0];
      rnd = lfsr_next(rnd);
      wr16(8'h7a, rnd);
      wr(8'h78, a);
      wr(8'h79, 8'hf2);
      `CHK(o_param_req, 1'b1)
      `CHK(o_param_write, 1'b1)
      `CHK(o_param_addr, a)
      `CHK(o_param_wdata, rnd)
      if (k[0]) begin
        rd(8'h79, c);
        `CHK(c, 8'h02)
      end
      poll_done();
      pmem[a] = rnd;
      a = k[1] ? a : a ^ 8'h01;
      wr(8'h78, a);
      wr(8'h79, 8'h01);
      `CHK(o_param_write, 1'b0)
      poll_done();
      rd16(8'h7a, got);
      `CHK(got, pmem[a])
    end
    wr(8'h79, 8'h03);
    `CHK(o_param_req, 1'b0)
    rd(8'h79, c);
    `CHK(c, 8'h00)
    stop_test();
  end
endmodule : test_output_geometry_and_config_mailbox
`default_nettype wire
